// ===== logic/psc_pkg.sv
// Purpose: constants for the strap, reset and clock-source configuration block
// Assumes: one 100 MHz system clock
// Notes: strap register bit positions follow the vendor status register layout
package psc_pkg;
   // ----------------------------------------------------------------
   // strap register layout
   // ----------------------------------------------------------------
   localparam int ADDR_W = 5;
   localparam int STRAP_REG_NUM = 17;
   localparam int STRAP_REG_W = 16;
   localparam int STRAP_MSB_POS = 8;
   localparam int STRAP_LSB_POS = 4;
   localparam logic [ADDR_W-1:0] ADDR_ZERO = 5'h00;
   localparam logic [STRAP_REG_W-1:0] STRAP_REG_RST = 16'h0000;
   // ----------------------------------------------------------------
   // timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int RESET_HOLD_MS = 30;
   localparam int RESET_HOLD_CYCLES = (RESET_HOLD_MS * 1000000) / CLK_PERIOD_NS;
   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      PSC_RESET = 3'h1,
      PSC_NORMAL = 3'h2,
      PSC_TEST = 3'h4
   } psc_state_t;
endpackage : psc_pkg

// ===== logic/psc_strap_cfg.sv
// Purpose: strap latch, output float gating and reference clock forwarding
// Assumes: strap and control inputs synchronous to clock_i; xtal_in already a clean level
// Notes: rst_n_i is the device reset pin, rst_i the logic power-on reset
`timescale 1ns/10ps
module psc_strap_cfg #(
   parameter int HOLD_CYCLES = psc_pkg::RESET_HOLD_CYCLES
) (
   // clock and resets
   input wire logic clock_i,
   input wire logic rst_i,
   input wire logic rst_n_i,
   // straps and controls
   input wire logic [psc_pkg::ADDR_W-1:0] strap_address_i,
   input wire logic clock_source_select_i,
   input wire logic output_float_ctl_i,
   input wire logic factory_test_sel_i,
   // crystal circuit
   input wire logic xtal_in_i,
   output logic xtal_out_o,
   output logic xtal_out_oe_o,
   // reference clock pin
   output logic ref_clock_out_o,
   output logic ref_clock_out_oe_o,
   // two-way pin direction and status
   output logic pin_dir_out_o,
   output logic [psc_pkg::STRAP_REG_W-1:0] strap_status_o,
   output logic addr_zero_o,
   output logic test_mode_o,
   output logic ready_o,
   output logic reset_short_o
);
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic [psc_pkg::STRAP_REG_W-1:0] place_addr(
      input logic [psc_pkg::ADDR_W-1:0] a);
      logic [psc_pkg::STRAP_REG_W-1:0] r;
      r = psc_pkg::STRAP_REG_RST;
      for (int i = 0; i < psc_pkg::ADDR_W; i++) begin
         r[psc_pkg::STRAP_MSB_POS - i] = a[i];
      end
      return r;
   endfunction : place_addr

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   psc_pkg::psc_state_t state, next_state;
   logic [psc_pkg::STRAP_REG_W-1:0] strap_reg, next_strap_reg;
   logic addr_zero, next_addr_zero;
   logic [31:0] hold_cnt, next_hold_cnt;
   logic reset_short, next_reset_short;
   logic ref_q, next_ref_q;
   logic ref_oe, next_ref_oe;
   logic xo_q, next_xo_q;
   logic xo_oe, next_xo_oe;
   logic dir_out, next_dir_out;
   logic test_mode, next_test_mode;
   logic ready, next_ready;

   always_comb begin
      next_state = state;
      next_strap_reg = strap_reg;
      next_addr_zero = addr_zero;
      next_hold_cnt = hold_cnt;
      next_reset_short = reset_short;
      case (state)
         psc_pkg::PSC_RESET: begin
            if (!rst_n_i) begin
               if (hold_cnt < 32'(HOLD_CYCLES)) begin
                  next_hold_cnt = hold_cnt + 32'h1;
               end
            end else begin
               next_strap_reg = place_addr(strap_address_i);
               next_addr_zero = (strap_address_i == psc_pkg::ADDR_ZERO);
               next_reset_short = (hold_cnt < 32'(HOLD_CYCLES));
               next_state = factory_test_sel_i ? psc_pkg::PSC_TEST : psc_pkg::PSC_NORMAL;
            end
         end
         psc_pkg::PSC_NORMAL, psc_pkg::PSC_TEST: begin
            next_state = factory_test_sel_i ? psc_pkg::PSC_TEST : psc_pkg::PSC_NORMAL;
         end
         default: begin
            next_state = psc_pkg::PSC_RESET;
         end
      endcase
      if (!rst_n_i) begin
         next_state = psc_pkg::PSC_RESET;
         next_strap_reg = psc_pkg::STRAP_REG_RST;
         next_addr_zero = 1'b0;
         // this low cycle already counts, so a reset of exactly the hold is not short
         if (state != psc_pkg::PSC_RESET) begin
            next_hold_cnt = 32'h1;
         end
      end
      // mode and ready decoded ahead so both pins leave a flop, not a compare
      next_test_mode = (next_state == psc_pkg::PSC_TEST);
      next_ready = (next_state != psc_pkg::PSC_RESET);
   end

   always_comb begin
      next_ref_q = xtal_in_i & ~output_float_ctl_i;
      next_ref_oe = ~output_float_ctl_i;
      next_dir_out = ~output_float_ctl_i;
      next_xo_q = ~xtal_in_i;
      next_xo_oe = ~clock_source_select_i;
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state <= psc_pkg::PSC_RESET;
         strap_reg <= psc_pkg::STRAP_REG_RST;
         addr_zero <= 1'b0;
         hold_cnt <= 32'h0;
         reset_short <= 1'b0;
         ref_q <= 1'b0;
         ref_oe <= 1'b0;
         xo_q <= 1'b0;
         xo_oe <= 1'b0;
         dir_out <= 1'b0;
         test_mode <= 1'b0;
         ready <= 1'b0;
      end else begin
         state <= next_state;
         strap_reg <= next_strap_reg;
         addr_zero <= next_addr_zero;
         hold_cnt <= next_hold_cnt;
         reset_short <= next_reset_short;
         ref_q <= next_ref_q;
         ref_oe <= next_ref_oe;
         xo_q <= next_xo_q;
         xo_oe <= next_xo_oe;
         dir_out <= next_dir_out;
         test_mode <= next_test_mode;
         ready <= next_ready;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   // the pin forward is one register late; a limitation of a fully registered output
   assign ref_clock_out_o = ref_q;
   assign ref_clock_out_oe_o = ref_oe;
   assign xtal_out_o = xo_q;
   assign xtal_out_oe_o = xo_oe;
   assign pin_dir_out_o = dir_out;
   assign strap_status_o = strap_reg;
   assign addr_zero_o = addr_zero;
   assign test_mode_o = test_mode;
   assign ready_o = ready;
   assign reset_short_o = reset_short;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   a_strap_capture: assert property (
      (state == psc_pkg::PSC_RESET && rst_n_i) |=>
      strap_status_o == place_addr($past(strap_address_i)))
      else $error("strap not captured at release");
   a_zero_flag: assert property (
      (state == psc_pkg::PSC_RESET && rst_n_i) |=>
      addr_zero_o == ($past(strap_address_i) == psc_pkg::ADDR_ZERO))
      else $error("zero address flag wrong");
   a_float_outputs: assert property (
      output_float_ctl_i |=> !ref_clock_out_oe_o && !pin_dir_out_o)
      else $error("outputs not floated");
   a_reset_init: assert property (
      !rst_n_i |=> !ready_o && strap_status_o == psc_pkg::STRAP_REG_RST)
      else $error("state not initialised under reset");
   a_short_reset: assert property (
      (state == psc_pkg::PSC_RESET && rst_n_i && hold_cnt < 32'(HOLD_CYCLES)) |=> reset_short_o)
      else $error("short reset not flagged");
   a_test_mode: assert property (
      (ready_o && rst_n_i) |=> test_mode_o == $past(factory_test_sel_i))
      else $error("test mode does not follow select");
   // the edge that ends rst_i still loads reset values, so it starts no attempt
   a_ref_forward: assert property (
      (!rst_i && !output_float_ctl_i) |=>
      ref_clock_out_o == $past(xtal_in_i) && ref_clock_out_oe_o)
      else $error("reference clock not forwarded");
   a_xtal_drive: assert property (
      clock_source_select_i |=> !xtal_out_oe_o)
      else $error("crystal output driven with oscillator");
   a_strap_hold: assert property (
      (ready_o && rst_n_i) ##1 rst_n_i |-> $stable(strap_status_o) [*2])
      else $error("strap value changed without reset");
   a_float_ref_low: assert property (
      output_float_ctl_i |=> !ref_clock_out_o)
      else $error("reference clock level not parked while floating");
   a_xtal_invert: assert property (
      (!rst_i && !clock_source_select_i) |=>
      xtal_out_oe_o && xtal_out_o == !$past(xtal_in_i))
      else $error("crystal output not driven as inverter");
   a_ready_release: assert property (
      (state == psc_pkg::PSC_RESET && rst_n_i) |=> ready_o)
      else $error("ready not raised after release");

   c_normal: cover property (ready_o && !test_mode_o);
   c_test: cover property (test_mode_o);
   c_zero: cover property (addr_zero_o);
   c_float: cover property (output_float_ctl_i ##1 !ref_clock_out_oe_o);
endmodule : psc_strap_cfg

// ===== tb/psc_board_model.sv
// Purpose: board side of the strap block, crystal or oscillator source
// Assumes: source level is synchronous to the system clock
// Notes: the reset pin and the straps are driven by the bench itself
`timescale 1ns/10ps
module psc_board_model (
   // clock
   input wire logic clock_i,
   // board choice
   input wire logic osc_mode_i,
   output logic xtal_in_o,
   output logic clock_source_select_o
);
   logic [1:0] ph = 2'h0;
   assign clock_source_select_o = osc_mode_i;
   // 25 MHz source, four system clocks a period
   always @(posedge clock_i) begin
      ph <= ph + 2'h1;
   end
   assign xtal_in_o = ph[1];
endmodule : psc_board_model

// ===== tb/tb_psc_strap_cfg.sv
// Purpose: bench for the strap, float and reference clock block
// Assumes: hold count shortened to 8 cycles
// Notes: strap image worked out bit by bit, not from the design
`timescale 1ns/10ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin num_errors++; \
   $display("Error t=%0t got %h exp %h", $time, a, e); end end
module tb_psc_strap_cfg;
   localparam int HOLD = 8;
   logic clock_i = 1'h0;
   logic rst_i = 1'h1;
   logic rst_n_i = 1'h0;
   logic [4:0] strap_address_i = 5'h00;
   logic output_float_ctl_i = 1'h0;
   logic factory_test_sel_i = 1'h0;
   logic osc_mode = 1'h0;
   logic clock_source_select_i, xtal_in_i, xtal_out_o, xtal_out_oe_o, ref_clock_out_o, x;
   logic ref_clock_out_oe_o, pin_dir_out_o, addr_zero_o, test_mode_o, ready_o, reset_short_o;
   logic [15:0] strap_status_o;
   logic [4:0] addrs [6] = '{5'h13, 5'h00, 5'h01, 5'h10, 5'h1f, 5'h0a};
   int num_errors = 0;
   int cmp_count = 0;
   psc_strap_cfg #(.HOLD_CYCLES(HOLD)) u_psc_strap_cfg (.clock_i(clock_i), .rst_i(rst_i),
      .rst_n_i(rst_n_i), .strap_address_i(strap_address_i),
      .clock_source_select_i(clock_source_select_i), .output_float_ctl_i(output_float_ctl_i),
      .factory_test_sel_i(factory_test_sel_i), .xtal_in_i(xtal_in_i), .xtal_out_o(xtal_out_o),
      .xtal_out_oe_o(xtal_out_oe_o), .ref_clock_out_o(ref_clock_out_o),
      .ref_clock_out_oe_o(ref_clock_out_oe_o), .pin_dir_out_o(pin_dir_out_o),
      .strap_status_o(strap_status_o), .addr_zero_o(addr_zero_o), .test_mode_o(test_mode_o),
      .ready_o(ready_o), .reset_short_o(reset_short_o));
   psc_board_model u_psc_board_model (.clock_i(clock_i), .osc_mode_i(osc_mode),
      .xtal_in_o(xtal_in_i), .clock_source_select_o(clock_source_select_i));
   initial begin
      forever #5 clock_i = ~clock_i;
   end
   function automatic logic [15:0] img(input logic [4:0] a);
      img = 16'h0000;
      for (int i = 0; i < 5; i++) img[8 - i] = a[i];
   endfunction : img
   task automatic tick(input int n);
      repeat (n) @(posedge clock_i);
      #1;
   endtask : tick
   // hold the pin low, look inside, release and wait for the answer
   task automatic strap_reset(input logic [4:0] a, input int hold);
      @(posedge clock_i);
      rst_n_i <= 1'h0;
      strap_address_i <= a;
      tick(hold);
      `CHK(ready_o, 1'h0)
      `CHK(strap_status_o, 16'h0000)
      @(posedge clock_i);
      rst_n_i <= 1'h1;
      tick(2);
   endtask : strap_reset
   task automatic print_verdict();
      $display("errors %0d compares %0d", num_errors, cmp_count);
      if (num_errors == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask : print_verdict
   initial begin
      #20000;
      num_errors++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge clock_i);
      rst_i <= 1'h0;
      foreach (addrs[k]) begin
         strap_reset(addrs[k], 10);
         `CHK(strap_status_o, img(addrs[k]))
         `CHK(addr_zero_o, addrs[k] === 5'h00)
         `CHK(reset_short_o, 1'h0)
         `CHK(ready_o, 1'h1)
      end
      @(posedge clock_i);
      strap_address_i <= 5'h05;
      tick(3);
      `CHK(strap_status_o, img(5'h0a))
      strap_reset(5'h04, 3);
      `CHK(reset_short_o, 1'h1)
      `CHK(strap_status_o, img(5'h04))
      for (int v = 1; v >= 0; v--) begin
         @(posedge clock_i);
         factory_test_sel_i <= v[0];
         tick(2);
         `CHK(test_mode_o, v[0])
      end
      for (int m = 0; m < 2; m++) begin
         @(posedge clock_i);
         osc_mode <= m[0];
         tick(2);
         repeat (6) begin
            x = xtal_in_i;
            tick(1);
            `CHK(ref_clock_out_o, x)
            `CHK(xtal_out_oe_o, ~m[0])
            if (!m[0]) `CHK(xtal_out_o, ~x)
         end
      end
      @(posedge clock_i);
      output_float_ctl_i <= 1'h1;
      tick(2);
      `CHK(ref_clock_out_oe_o, 1'h0)
      `CHK(pin_dir_out_o, 1'h0)
      `CHK(ref_clock_out_o, 1'h0)
      @(posedge clock_i);
      output_float_ctl_i <= 1'h0;
      tick(2);
      `CHK(pin_dir_out_o, 1'h1)
      `CHK(ref_clock_out_oe_o, 1'h1)
      print_verdict();
   end
endmodule : tb_psc_strap_cfg
